//--- logic/smu_pkg.sv
package smu_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] SMU_CMD_OFF = 8'h00;
  localparam logic [7:0] SMU_OPA_OFF = 8'h04;
  localparam logic [7:0] SMU_OPB_OFF = 8'h08;
  localparam logic [7:0] SMU_RESULT_OFF = 8'h0C;
  localparam logic [7:0] SMU_CTRL_OFF = 8'h10;
  localparam logic [7:0] SMU_ACC_HI_OFF = 8'h14;
  localparam logic [7:0] SMU_ACC_LO_OFF = 8'h18;
  localparam logic [7:0] SMU_LOAD_DATA_OFF = 8'h1C;
  localparam logic [7:0] SMU_LOAD_ADDR_OFF = 8'h20;
  localparam logic [7:0] SMU_STATUS_OFF = 8'h24;

  // ----------------------------------------------------------------
  // Status-control word layout
  // ----------------------------------------------------------------
  localparam int POS_LSB = 0;
  localparam int POS_W = 6;
  localparam int SCNT_LSB = 6;
  localparam int SCNT_W = 6;
  localparam int CARRY_BIT = 12;
  localparam int OUF_LSB = 13;
  localparam int OUF_W = 8;
  localparam int CCOND_LSB = 21;
  localparam int CCOND_W = 4;
  localparam int EFI_BIT = 25;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // Mask bit numbers for the masked control-word access
  localparam int MASK_POS = 0;
  localparam int MASK_SCNT = 1;
  localparam int MASK_CARRY = 2;
  localparam int MASK_OUF = 3;
  localparam int MASK_CCOND = 4;
  localparam int MASK_EFI = 5;

  // Status register bits
  localparam int STAT_BRANCH = 0;
  localparam int STAT_PENDING = 1;

  // ----------------------------------------------------------------
  // Arithmetic constants
  // ----------------------------------------------------------------
  localparam logic [15:0] Q15_NEG1 = 16'h8000;
  localparam logic [15:0] Q15_MAX = 16'h7FFF;
  localparam logic [15:0] U16_MAX = 16'hFFFF;
  localparam logic [31:0] Q31_NEG1 = 32'h8000_0000;
  localparam logic [31:0] Q31_MAX = 32'h7FFF_FFFF;
  localparam logic [31:0] ROUND_HALF = 32'h0000_8000;
  localparam logic [63:0] Q63_MAX = 64'h7FFF_FFFF_FFFF_FFFF;
  localparam logic [63:0] Q63_MIN = 64'h8000_0000_0000_0000;
  localparam logic [5:0] BRANCH_POS_LIMIT = 6'h20;
  localparam int MODSUB_STEP_W = 8;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Operations and command word
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP, OP_MUL_BH, OP_MUL_PH, OP_MUL_HSEL, OP_MAC_HSEL,
    OP_LOAD_W, OP_LOAD_H, OP_LOAD_B, OP_WR_CTRL, OP_RD_CTRL,
    OP_EXTR, OP_EXTP, OP_EXTPDP, OP_SHILO, OP_FILL,
    OP_DOT_ADD, OP_DOT_SUB, OP_DIFF, OP_DOTU_ADD, OP_DOTU_SUB,
    OP_MACW_ADD, OP_MACW_SUB, OP_BRANCH, OP_MODSUB, OP_INSV, OP_BITREV
  } smu_op_e;

  typedef struct packed {
    logic [9:0] rsv_hi;   // Reads back as written, no effect
    logic [5:0] imm;      // Immediate amount, length or mask
    logic [4:0] rsv_lo;
    logic amt_reg;        // Take amount from operand B instead
    logic [1:0] acc;      // Accumulator number
    logic sat;            // Saturating form
    logic rnd;            // Rounding form
    logic left;           // High half / high bytes select
    smu_op_e op;
  } smu_cmd_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic pending;
    smu_cmd_s cmd;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] result;
    logic [31:0] ctrl;
    logic [31:0] load_data;
    logic [31:0] load_addr;
    logic branch_taken;
    logic [3:0][63:0] acc;
  } smu_state_s;

endpackage : smu_pkg

//--- logic/smu_mac_unit.sv
`timescale 1ns/10ps
// Summary of operation
// - GPR multiplies also overwrite accumulator zero
// - Byte-by-half multiply, unsigned saturate each half
// - Paired Q15 multiply, round, saturate, pack
// - Half-select Q15 multiply to Q31, saturate minus-one squared
// - Half-select product added into 64-bit accumulator
// - Saturating form clamps accumulator to Q31
// - Indexed loads: word, signed half, unsigned byte
// - Masked control write and masked zeroing read
// - Mask bits select pos, scount, carry, flags, ccond, efi
// - Accumulator extract with optional round and saturate
// - Positioned field extract, msb at pos
// - Decrementing extract moves pos below field
// - Accumulator shift, positive right, negative left
// - Fill: low half up, operand into low
// - Q15 dot product saturated, added or subtracted
// - Difference of products replaces accumulator
// - Unsigned byte dot product added or subtracted
// - Q31 multiply-accumulate saturated twice
// - Position branch taken when pos at least 32
// - Circular index decrement wraps to maximum
// - Variable insert at pos, width scount
// - Reverse low 16 bits, clear upper half
module smu_mac_unit
  import smu_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Q15 x Q15 to Q31; only minus one squared overflows
  function automatic logic [31:0] q15mul(input logic [15:0] a, input logic [15:0] b);
    logic signed [31:0] p;
    p = $signed(a) * $signed(b);
    if (a == Q15_NEG1 && b == Q15_NEG1) begin
      q15mul = Q31_MAX;
    end else begin
      q15mul = {p[30:0], 1'b0};
    end
  endfunction : q15mul

  // Q15 x Q15 rounded back to Q15
  function automatic logic [15:0] q15rnd(input logic [15:0] a, input logic [15:0] b);
    logic [31:0] r;
    r = q15mul(a, b) + ROUND_HALF;
    if (a == Q15_NEG1 && b == Q15_NEG1) begin
      q15rnd = Q15_MAX;
    end else begin
      q15rnd = r[31:16];
    end
  endfunction : q15rnd

  // Q31 x Q31 to Q63; only minus one squared overflows
  function automatic logic [63:0] q31mul(input logic [31:0] a, input logic [31:0] b);
    logic signed [63:0] p;
    p = $signed(a) * $signed(b);
    if (a == Q31_NEG1 && b == Q31_NEG1) begin
      q31mul = Q63_MAX;
    end else begin
      q31mul = {p[62:0], 1'b0};
    end
  endfunction : q31mul

  // Sign extend a word to accumulator width
  function automatic logic [63:0] sx(input logic [31:0] v);
    sx = {{32{v[31]}}, v};
  endfunction : sx

  // Clamp a 64-bit signed value to signed 32 bits
  function automatic logic [31:0] sat_q31(input logic [63:0] v);
    if (v[63:31] == '0 || v[63:31] == '1) begin
      sat_q31 = v[31:0];
    end else begin
      sat_q31 = v[63] ? Q31_NEG1 : Q31_MAX;
    end
  endfunction : sat_q31

  // Unsigned clamp to 16 bits
  function automatic logic [15:0] usat16(input logic [31:0] v);
    usat16 = (v > {16'h0000, U16_MAX}) ? U16_MAX : v[15:0];
  endfunction : usat16

  // Mask of the low w bits, w up to 32
  function automatic logic [31:0] fmask(input logic [5:0] w);
    logic [32:0] m;
    m = (33'h0_0000_0001 << w) - 33'h0_0000_0001;
    fmask = (w >= BRANCH_POS_LIMIT) ? '1 : m[31:0];
  endfunction : fmask

  // Expand the 6-bit field mask into a control-word bit mask
  function automatic logic [31:0] ctrl_mask(input logic [5:0] mk);
    logic [31:0] m;
    m = '0;
    if (mk[MASK_POS]) m[POS_LSB +: POS_W] = '1;
    if (mk[MASK_SCNT]) m[SCNT_LSB +: SCNT_W] = '1;
    if (mk[MASK_CARRY]) m[CARRY_BIT] = 1'b1;
    if (mk[MASK_OUF]) m[OUF_LSB +: OUF_W] = '1;
    if (mk[MASK_CCOND]) m[CCOND_LSB +: CCOND_W] = '1;
    if (mk[MASK_EFI]) m[EFI_BIT] = 1'b1;
    ctrl_mask = m;
  endfunction : ctrl_mask

  // Byte-lane merge under write strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    merge = r;
  endfunction : merge

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  smu_state_s s_reg; // Every flip-flop of the block
  smu_state_s s_next; // Its next value

  // ----------------------------------------------------------------
  // Next-state logic: bus slave and datapath
  // ----------------------------------------------------------------
  always_comb begin
    smu_cmd_s c;
    logic [63:0] acc_v;
    logic [63:0] t64;
    logic [63:0] u64;
    logic [64:0] w65;
    logic [31:0] r32;
    logic [31:0] m32;
    logic [31:0] lane;
    logic [15:0] a_h;
    logic [15:0] b_h;
    logic [15:0] rev;
    logic [5:0] amt;
    logic [5:0] pos;
    logic [4:0] sz;
    logic mul_gpr;
    c = s_reg.cmd;
    acc_v = s_reg.acc[c.acc];
    t64 = '0;
    u64 = '0;
    w65 = '0;
    r32 = '0;
    m32 = ctrl_mask(c.imm);
    lane = '0;
    a_h = c.left ? s_reg.opa[31:16] : s_reg.opa[15:0];
    b_h = c.left ? s_reg.opb[31:16] : s_reg.opb[15:0];
    rev = '0;
    amt = c.amt_reg ? s_reg.opb[5:0] : c.imm;
    pos = s_reg.ctrl[POS_LSB +: POS_W];
    sz = amt[4:0];
    mul_gpr = 1'b0;
    s_next = s_reg;
    s_next.pending = 1'b0;

    // Write address and data are taken independently, in either order
    if (s_reg.awready && awvalid) begin
      s_next.awready = 1'b0;
      s_next.aw_got = 1'b1;
      s_next.waddr = awaddr;
    end
    if (s_reg.wready && wvalid) begin
      s_next.wready = 1'b0;
      s_next.w_got = 1'b1;
      s_next.wdata = wdata;
      s_next.wstrb = wstrb;
    end

    // Commit once both halves are held; decode on the aligned word
    if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = RESP_OKAY;
      if ({s_reg.waddr[7:2], 2'h0} == SMU_CMD_OFF) begin
        // A command write launches the operation next cycle
        s_next.cmd = smu_cmd_s'(merge(s_reg.cmd, s_reg.wdata, s_reg.wstrb));
        s_next.pending = 1'b1;
      end else if ({s_reg.waddr[7:2], 2'h0} == SMU_OPA_OFF) begin
        s_next.opa = merge(s_reg.opa, s_reg.wdata, s_reg.wstrb);
      end else if ({s_reg.waddr[7:2], 2'h0} == SMU_OPB_OFF) begin
        s_next.opb = merge(s_reg.opb, s_reg.wdata, s_reg.wstrb);
      end else if ({s_reg.waddr[7:2], 2'h0} == SMU_CTRL_OFF) begin
        s_next.ctrl = merge(s_reg.ctrl, s_reg.wdata, s_reg.wstrb);
      end else if ({s_reg.waddr[7:2], 2'h0} == SMU_ACC_HI_OFF) begin
        s_next.acc[c.acc][63:32] = merge(acc_v[63:32], s_reg.wdata, s_reg.wstrb);
      end else if ({s_reg.waddr[7:2], 2'h0} == SMU_ACC_LO_OFF) begin
        s_next.acc[c.acc][31:0] = merge(acc_v[31:0], s_reg.wdata, s_reg.wstrb);
      end else if ({s_reg.waddr[7:2], 2'h0} == SMU_LOAD_DATA_OFF) begin
        s_next.load_data = merge(s_reg.load_data, s_reg.wdata, s_reg.wstrb);
      end else if ({s_reg.waddr[7:2], 2'h0} == SMU_RESULT_OFF ||
                   {s_reg.waddr[7:2], 2'h0} == SMU_LOAD_ADDR_OFF ||
                   {s_reg.waddr[7:2], 2'h0} == SMU_STATUS_OFF) begin
        // Read-only words ignore writes
      end else begin
        s_next.bresp = RESP_SLVERR;
      end
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
      s_next.awready = 1'b1;
      s_next.wready = 1'b1;
    end

    // Read channel: one outstanding read, answer one cycle after address
    if (s_reg.arready && arvalid) begin
      s_next.arready = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rresp = RESP_OKAY;
      if ({araddr[7:2], 2'h0} == SMU_CMD_OFF) begin
        s_next.rdata = s_reg.cmd;
      end else if ({araddr[7:2], 2'h0} == SMU_OPA_OFF) begin
        s_next.rdata = s_reg.opa;
      end else if ({araddr[7:2], 2'h0} == SMU_OPB_OFF) begin
        s_next.rdata = s_reg.opb;
      end else if ({araddr[7:2], 2'h0} == SMU_RESULT_OFF) begin
        s_next.rdata = s_reg.result;
      end else if ({araddr[7:2], 2'h0} == SMU_CTRL_OFF) begin
        s_next.rdata = s_reg.ctrl;
      end else if ({araddr[7:2], 2'h0} == SMU_ACC_HI_OFF) begin
        s_next.rdata = acc_v[63:32];
      end else if ({araddr[7:2], 2'h0} == SMU_ACC_LO_OFF) begin
        s_next.rdata = acc_v[31:0];
      end else if ({araddr[7:2], 2'h0} == SMU_LOAD_DATA_OFF) begin
        s_next.rdata = s_reg.load_data;
      end else if ({araddr[7:2], 2'h0} == SMU_LOAD_ADDR_OFF) begin
        s_next.rdata = s_reg.load_addr;
      end else if ({araddr[7:2], 2'h0} == SMU_STATUS_OFF) begin
        s_next.rdata = '0;
        s_next.rdata[STAT_BRANCH] = s_reg.branch_taken;
        s_next.rdata[STAT_PENDING] = s_reg.pending;
      end else begin
        s_next.rdata = '0;
        s_next.rresp = RESP_SLVERR;
      end
    end
    if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end

    // Datapath: runs one cycle after the command write commits.
    // Bus commits cannot collide with it, since bvalid is still high.
    if (s_reg.pending) begin
      case (c.op)
        OP_MUL_BH: begin
          // Bytes from A, halves from B, 8x16 unsigned products
          lane = c.left ? {16'h0000, s_reg.opa[31:16]} : {16'h0000, s_reg.opa[15:0]};
          r32[31:16] = usat16({24'h00_0000, lane[15:8]} * {16'h0000, s_reg.opb[31:16]});
          r32[15:0] = usat16({24'h00_0000, lane[7:0]} * {16'h0000, s_reg.opb[15:0]});
          mul_gpr = 1'b1;
        end
        OP_MUL_PH: begin
          r32 = {q15rnd(s_reg.opa[31:16], s_reg.opb[31:16]),
                 q15rnd(s_reg.opa[15:0], s_reg.opb[15:0])};
          mul_gpr = 1'b1;
        end
        OP_MUL_HSEL: begin
          r32 = q15mul(a_h, b_h);
          mul_gpr = 1'b1;
        end
        OP_MAC_HSEL: begin
          t64 = acc_v + sx(q15mul(a_h, b_h));
          if (c.sat) t64 = sx(sat_q31(t64));
          s_next.acc[c.acc] = t64;
        end
        OP_LOAD_W, OP_LOAD_H, OP_LOAD_B: begin
          // Address from two registers; memory word mirrored in load data
          r32 = s_reg.opa + s_reg.opb;
          s_next.load_addr = r32;
          lane = s_reg.load_data >> {r32[1:0], 3'h0};
          if (c.op == OP_LOAD_W) begin
            s_next.result = s_reg.load_data;
          end else if (c.op == OP_LOAD_H) begin
            lane = r32[1] ? {16'h0000, s_reg.load_data[31:16]}
                          : {16'h0000, s_reg.load_data[15:0]};
            s_next.result = {{16{lane[15]}}, lane[15:0]};
          end else begin
            s_next.result = {24'h00_0000, lane[7:0]};
          end
        end
        OP_WR_CTRL: begin
          s_next.ctrl = (s_reg.ctrl & ~m32) | (s_reg.opa & m32);
        end
        OP_RD_CTRL: begin
          s_next.result = s_reg.ctrl & m32;
        end
        OP_EXTR: begin
          // Keep one guard bit so rounding adds half an output unit
          w65 = 65'($signed({acc_v, 1'b0}) >>> sz);
          if (c.rnd) w65 = w65 + 65'h0_0000_0000_0000_0001;
          t64 = w65[64:1];
          s_next.result = c.sat ? sat_q31(t64) : t64[31:0];
        end
        OP_EXTP, OP_EXTPDP: begin
          // Field runs from pos down size+1 bits; too few bits flags failure
          if (pos < {1'b0, sz}) begin
            s_next.ctrl[EFI_BIT] = 1'b1;
          end else begin
            s_next.ctrl[EFI_BIT] = 1'b0;
            t64 = acc_v >> (pos - {1'b0, sz});
            s_next.result = t64[31:0] & fmask({1'b0, sz} + 6'h01);
            if (c.op == OP_EXTPDP) begin
              s_next.ctrl[POS_LSB +: POS_W] = pos - {1'b0, sz} - 6'h01;
            end
          end
        end
        OP_SHILO: begin
          if (amt[5]) begin
            s_next.acc[c.acc] = acc_v << (6'h00 - amt);
          end else begin
            s_next.acc[c.acc] = acc_v >> amt;
          end
        end
        OP_FILL: begin
          s_next.acc[c.acc] = {acc_v[31:0], s_reg.opa};
        end
        OP_DOT_ADD, OP_DOT_SUB: begin
          t64 = sx(q15mul(s_reg.opa[31:16], s_reg.opb[31:16])) +
                sx(q15mul(s_reg.opa[15:0], s_reg.opb[15:0]));
          t64 = sx(sat_q31(t64));
          s_next.acc[c.acc] = (c.op == OP_DOT_ADD) ? acc_v + t64 : acc_v - t64;
        end
        OP_DIFF: begin
          s_next.acc[c.acc] = sx(q15mul(s_reg.opa[31:16], s_reg.opb[31:16])) -
                              sx(q15mul(s_reg.opa[15:0], s_reg.opb[15:0]));
        end
        OP_DOTU_ADD, OP_DOTU_SUB: begin
          lane = c.left ? {s_reg.opa[31:16], s_reg.opb[31:16]}
                        : {s_reg.opa[15:0], s_reg.opb[15:0]};
          t64 = {48'h0000_0000_0000, {8'h00, lane[31:24]} * {8'h00, lane[15:8]}} +
                {48'h0000_0000_0000, {8'h00, lane[23:16]} * {8'h00, lane[7:0]}};
          s_next.acc[c.acc] = (c.op == OP_DOTU_ADD) ? acc_v + t64 : acc_v - t64;
        end
        OP_MACW_ADD, OP_MACW_SUB: begin
          t64 = q31mul(s_reg.opa, s_reg.opb);
          w65 = (c.op == OP_MACW_ADD) ? {acc_v[63], acc_v} + {t64[63], t64}
                                      : {acc_v[63], acc_v} - {t64[63], t64};
          if (w65[64] != w65[63]) begin
            s_next.acc[c.acc] = w65[64] ? Q63_MIN : Q63_MAX;
          end else begin
            s_next.acc[c.acc] = w65[63:0];
          end
        end
        OP_BRANCH: begin
          s_next.branch_taken = (pos >= BRANCH_POS_LIMIT);
        end
        OP_MODSUB: begin
          // Step in the low byte, maximum index above it
          if (s_reg.opa == '0) begin
            s_next.result = {8'h00, s_reg.opb[31:MODSUB_STEP_W]};
          end else begin
            s_next.result = s_reg.opa - {24'h00_0000, s_reg.opb[MODSUB_STEP_W-1:0]};
          end
        end
        OP_INSV: begin
          m32 = fmask(s_reg.ctrl[SCNT_LSB +: SCNT_W]);
          t64 = {32'h0000_0000, m32} << pos;
          u64 = {32'h0000_0000, s_reg.opa & m32} << pos;
          s_next.result = (s_reg.opb & ~t64[31:0]) | u64[31:0];
        end
        OP_BITREV: begin
          for (int i = 0; i < 16; i++) begin
            rev[i] = s_reg.opa[15 - i];
          end
          s_next.result = {16'h0000, rev};
        end
        default: begin
          // No operation
        end
      endcase
      // Multiplies to a GPR still clobber accumulator zero
      if (mul_gpr) begin
        s_next.result = r32;
        s_next.acc[0] = sx(r32);
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg <= '0;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
      s_reg.ctrl <= CTRL_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state flops
  assign awready = s_reg.awready;
  assign wready = s_reg.wready;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign arready = s_reg.arready;
  assign rvalid = s_reg.rvalid;
  assign rresp = s_reg.rresp;
  assign rdata = s_reg.rdata;

endmodule : smu_mac_unit

//--- tb/smu_mac_unit_monitor.sv
`timescale 1ns/10ps
module smu_mac_unit_monitor
  import smu_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready
);
  // ----------------------------------------------------------------
  // Bus timing; a stuck ready would hang software, so bound it
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_resp; !bvalid ##1 bvalid; endsequence
  property p_blat; awvalid && awready && wvalid && wready |-> ##1 s_resp; endproperty
  a_blat: assert property (p_blat) else $error("write answer not after two edges");
  property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_bend; bvalid && bready |=> !bvalid && awready && wready; endproperty
  a_bend: assert property (p_bend) else $error("write channel not reopened");
  property p_wblk; bvalid |-> !awready && !wready; endproperty
  a_wblk: assert property (p_wblk) else $error("write taken while answer pending");
  property p_rlat; arvalid && arready |=> rvalid && !arready; endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_rend; rvalid && rready |=> !rvalid && arready; endproperty
  a_rend: assert property (p_rend) else $error("read channel not reopened");
  property p_rbad; arvalid && arready && araddr[7:2] > 6'h09 |=> rresp == RESP_SLVERR
    && rdata == 32'h0000_0000; endproperty
  a_rbad: assert property (p_rbad) else $error("unmapped read not refused");
endmodule : smu_mac_unit_monitor
bind smu_mac_unit smu_mac_unit_monitor u_mon (.aclk, .aresetn, .awaddr, .awvalid, .awready,
  .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
  .rdata, .rresp, .rvalid, .rready);

//--- tb/smu_axi_master.sv
`timescale 1ns/10ps
module smu_axi_master
  import smu_pkg::*;
(
  input wire logic aclk,
  output logic [ADDR_W-1:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [ADDR_W-1:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // Answer readies stay high, so no line is toggled twice in one step
  initial begin
    {awvalid, wvalid, arvalid, awaddr, araddr, wdata, wstrb} = '0;
    {bready, rready} = 2'h3;
  end
  // Released payload goes to its inverse, not a stale copy
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta;
    logic tw;
    {ta, tw} = 2'h0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    {awvalid, wvalid} <= 2'h3;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (!ta && awready) begin ta = 1; awvalid <= 0; awaddr <= ~a; end
      if (!tw && wready) begin tw = 1; wvalid <= 0; wdata <= ~d; end
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    araddr <= ~a;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
  endtask : rd
endmodule : smu_axi_master

//--- tb/tb.sv
`timescale 1ns/10ps
module tb;
  import smu_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, x, y, r, e, seed = 32'h0000_4829;
  logic [63:0] q;
  logic [5:0] s;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  // Field masks of the status-control word, by mask bit
  localparam logic [31:0] FM [6] = '{32'h0000_003F, 32'h0000_0FC0, 32'h0000_1000,
    32'h001F_E000, 32'h01E0_0000, 32'h0200_0000};
  always #10 aclk = ~aclk;
  smu_mac_unit dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready);
  smu_axi_master m (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [31:0] cw(logic [4:0] op, logic [5:0] imm, logic lf);
    return {10'h000, imm, 10'h000, lf, op};
  endfunction : cw
  function automatic logic [31:0] hsel(logic [15:0] a, logic [15:0] b);
    logic signed [31:0] p;
    p = $signed(a) * $signed(b);
    return (a == Q15_NEG1 && b == Q15_NEG1) ? Q31_MAX : p <<< 1;
  endfunction : hsel
  function automatic logic [15:0] bh(logic [7:0] a, logic [15:0] b);
    logic [23:0] p;
    p = a * b;
    return (p > 24'h00_FFFF) ? U16_MAX : p[15:0];
  endfunction : bh
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input logic [31:0] c, input logic [31:0] a, input logic [31:0] b);
    m.wr(SMU_OPA_OFF, a, rs);
    m.wr(SMU_OPB_OFF, b, rs);
    m.wr(SMU_CMD_OFF, c, rs);
    m.rd(SMU_RESULT_OFF, r, rs);
  endtask : run
  task automatic summarize();
    if (err_count == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  // Cut a hang short well past the expected run length
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin err_count++; summarize(); end
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    m.rd(8'h3C, r, rs);
    chk({r[31:2], rs}, {30'h0, RESP_SLVERR});
    m.wr(8'h3C, 0, rs);
    chk(rs, RESP_SLVERR);
    for (int i = 0; i < 6; i++) begin
      m.wr(SMU_CTRL_OFF, 32'h0000_0000, rs);
      run(cw(OP_WR_CTRL, 6'(1 << i), 0), 32'hFFFF_FFFF, 0);
      m.rd(SMU_CTRL_OFF, r, rs);
      chk(r, FM[i]);
    end
    for (int i = 31; i < 33; i++) begin
      m.wr(SMU_CTRL_OFF, 32'(i), rs);
      run(cw(OP_BRANCH, 0, 0), 0, 0);
      m.rd(SMU_STATUS_OFF, r, rs);
      chk(r & 32'h0000_0001, 32'(i == 32));
    end
    // First pass is the minus-one corner, the rest random
    for (int i = 0; i < 24; i++) begin
      x = i ? rnd() : 32'h8000_8000;
      y = i ? rnd() : x;
      run(cw(OP_MUL_HSEL, 0, x[0]), x, y);
      e = x[0] ? hsel(x[31:16], y[31:16]) : hsel(x[15:0], y[15:0]);
      chk(r, e);
      m.rd(SMU_ACC_HI_OFF, r, rs);
      chk(r, {32{e[31]}});
      run(cw(OP_MUL_BH, 0, x[1]), x, y);
      e = x[1] ? {bh(x[31:24], y[31:16]), bh(x[23:16], y[15:0])}
        : {bh(x[15:8], y[31:16]), bh(x[7:0], y[15:0])};
      chk(r, e);
      run(cw(OP_BITREV, 0, 0), x, y);
      e = {<<{x[15:0], 16'h0000}};
      chk(r, e);
      run(cw(OP_MODSUB, 0, 0), i[0] ? x : 0, y);
      chk(r, i[0] ? x - {24'h0, y[7:0]} : {8'h00, y[31:8]});
      m.wr(SMU_CTRL_OFF, 32'h0000_0204, rs);
      run(cw(OP_INSV, 0, 0), x, y);
      chk(r, y & 32'hFFFF_F00F | x[7:0] << 4);
      m.wr(SMU_CTRL_OFF, 32'h03FF_FFFF, rs);
      run(cw(OP_RD_CTRL, x[5:0], 0), 0, 0);
      e = 0;
      for (int k = 0; k < 6; k++) e = x[k] ? e | FM[k] : e;
      chk(r, e);
      s = (i == 0) ? 6'h20 : (i == 1) ? 6'h1F : y[5:0];
      m.wr(SMU_ACC_HI_OFF, x, rs);
      m.wr(SMU_ACC_LO_OFF, y, rs);
      run(cw(OP_SHILO, s, 0), 0, 0);
      q = s[5] ? {x, y} << (7'h40 - {1'b0, s}) : {x, y} >> s;
      m.rd(SMU_ACC_HI_OFF, r, rs);
      chk(r, q[63:32]);
      run(cw(OP_FILL, 0, 0), y, 0);
      m.rd(SMU_ACC_HI_OFF, r, rs);
      chk(r, q[31:0]);
      m.rd(SMU_ACC_LO_OFF, r, rs);
      chk(r, y);
      run(cw(OP_EXTPDP, 6'h07, 0), 0, 0);
      chk(r, q[31:24]);
      m.rd(SMU_CTRL_OFF, r, rs);
      chk(r, 32'h01FF_FFF7);
    end
    summarize();
  end
endmodule : tb
